// file: inc/sms_pkg.sv
package sms_pkg;
  // ****************************************
  // Sizes and timing
  // ****************************************
  localparam int unsigned NUM_MKR      = 5;
  localparam int unsigned FREQ_W       = 36;
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned TONE_HZ      = 5_000;
  localparam int unsigned TONE_HALF    = CLK_HZ / (2 * TONE_HZ);
  localparam int unsigned TONE_W       = 10;
  localparam logic [FREQ_W-1:0] FREQ_MIN = 36'h0_7735_9400;
  localparam logic [FREQ_W-1:0] FREQ_MAX = 36'h4_30E2_3400;
  localparam logic [FREQ_W-1:0] HI_BAND  = 36'h1_8964_0C00;
  localparam logic [FREQ_W-1:0] FINE_RES = 36'h0_0000_07D0;
  // ****************************************
  // Reset values and error codes
  // ****************************************
  localparam logic [FREQ_W-1:0] MKR_RST  = 36'h0_0000_0000;
  localparam logic [7:0] ERR_NONE     = 8'h00;
  localparam logic [7:0] ERR_BAD_MKR  = 8'h09;
  localparam logic [7:0] ERR_EQUAL    = 8'h0A;
  localparam logic [7:0] ERR_LOW      = 8'h0B;
  localparam logic [7:0] ERR_HIGH     = 8'h0C;
  localparam logic [7:0] ERR_PEAK     = 8'h5A;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {SMS_AUTO, SMS_MANUAL, SMS_SINGLE} sms_mode_t;
  typedef enum {SMS_IDLE, SMS_CMD_M, SMS_CMD_W, SMS_SEL, SMS_NUM, SMS_UNIT, SMS_MO}
    sms_pst_t;
endpackage : sms_pkg

// file: hw/sms_sweep_marker_sequencer.sv
// Functional notes
// - Five markers, each frequency and enable
// - Each enabled in-span marker adds its own point
// - Intensify output only on marker points
// - Tone output 5 kHz square on markers
// - Writing marker frequency also enables it
// - Out-of-span markers neither active nor generated
// - Marker-off: numbered one, else all five
// - Selecting marker for readback enables it
// - Active list follows sweep order
// - Above 6.6 GHz round to 2 kHz
// - Select letter plus digit; zero disables all
// - Selected marker then off code disables it
// - Select alone enables that marker
// - Number plus GZ/MZ/KZ/HZ scaled accordingly
// - Readback returns frequency in hertz
// - Equal start and stop: error 10, no sweep
// - Start below range: error 11, hold low
// - Stop above range: error 12, hold high
// - Auto-peak failure reports error 90
// - W2 auto, W3 manual, W6 single arm
// - Marker point precedes coincident ordinary point
// - Ordinary point after marker has indications off
// - Marker at start comes after start point
// - Letters accepted in any case
`timescale 1ns/100ps
`default_nettype none
module sms_sweep_marker_sequencer
  import sms_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              char_valid_i,
  input  wire logic [7:0]        char_i,
  input  wire logic [FREQ_W-1:0] start_freq_i,
  input  wire logic [FREQ_W-1:0] stop_freq_i,
  input  wire logic [FREQ_W-1:0] step_freq_i,
  input  wire logic              point_adv_i,
  input  wire logic              peak_fail_i,
  output logic [1:0]             sweep_mode_o,
  output logic                   single_arm_o,
  output logic [FREQ_W-1:0]      point_freq_o,
  output logic                   sweep_run_o,
  output logic                   marker_intensify_o,
  output logic                   tone_marker_output_o,
  output logic [NUM_MKR-1:0]     marker_active_o,
  output logic [14:0]            active_order_o,
  output logic [7:0]             error_code_o,
  output logic                   readback_valid_o,
  output logic [2:0]             readback_mkr_o,
  output logic [FREQ_W-1:0]      readback_freq_o
);
  // ****************************************
  // Pin synchroniser for peak_fail_i
  // ****************************************
  logic [1:0] pk_sync_q;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pk_sync_q <= 2'h0;
    end else begin
      pk_sync_q <= {pk_sync_q[0], peak_fail_i};
    end
  end
  // ****************************************
  // Command parser
  // ****************************************
  sms_pst_t              pst_q, pst_d;
  logic [2:0]            sel_q, sel_d;
  logic [FREQ_W+11:0]    num_q, num_d;
  logic [3:0]            frac_q, frac_d;
  logic                  dot_q, dot_d;
  logic [7:0]            unit_q, unit_d;
  logic [FREQ_W-1:0]     mfreq_q [NUM_MKR];
  logic [FREQ_W-1:0]     mfreq_d [NUM_MKR];
  logic [NUM_MKR-1:0]    men_q, men_d;
  logic [1:0]            mode_q, mode_d;
  logic                  arm_d;
  logic [7:0]            perr_q, perr_d;
  logic                  rb_d;
  logic [7:0]            up;
  logic [FREQ_W+11:0]    scaled;
  logic [FREQ_W+11:0]    rounded;
  logic                  is_dig;
  always_comb begin
    up      = (char_i >= 8'h61 && char_i <= 8'h7A) ? char_i - 8'h20 : char_i;
    is_dig  = char_i >= 8'h30 && char_i <= 8'h39;
    pst_d   = pst_q;
    sel_d   = sel_q;
    num_d   = num_q;
    frac_d  = frac_q;
    dot_d   = dot_q;
    unit_d  = unit_q;
    mfreq_d = mfreq_q;
    men_d   = men_q;
    mode_d  = mode_q;
    arm_d   = 1'b0;
    perr_d  = perr_q;
    rb_d    = 1'b0;
    unique case (unit_q)
      8'h47:   scaled = 48'(num_q * 48'd1_000_000_000);
      8'h4D:   scaled = 48'(num_q * 48'd1_000_000);
      8'h4B:   scaled = 48'(num_q * 48'd1_000);
      default: scaled = num_q;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (4'(i) < frac_q) begin
        scaled = scaled / 48'd10;
      end
    end
    rounded = scaled;
    if (scaled > {12'h000, HI_BAND}) begin
      rounded = scaled - (scaled % {12'h000, FINE_RES});
    end
    if (char_valid_i) begin
      unique case (pst_q)
        SMS_IDLE, SMS_SEL, SMS_NUM: begin
          if (is_dig && pst_q != SMS_IDLE) begin
            pst_d = SMS_NUM;
            num_d = 48'(num_q * 48'd10 + 48'(char_i - 8'h30));
            if (dot_q) begin
              frac_d = frac_q + 4'h1;
            end
          end else if (char_i == 8'h2E && pst_q != SMS_IDLE) begin
            dot_d = 1'b1;
            pst_d = SMS_NUM;
          end else if (up == 8'h4D || up == 8'h58) begin
            pst_d = SMS_CMD_M;
            // A fresh select letter forgets any earlier marker
            if (pst_q == SMS_IDLE) begin
              sel_d = 3'h0;
            end
            // M right after a number is the megahertz terminator
            if (pst_q == SMS_NUM) begin
              unit_d = 8'h4D;
            end
          end else if (up == 8'h57) begin
            pst_d = SMS_CMD_W;
          end else if (up == 8'h3F && pst_q == SMS_SEL) begin
            rb_d  = 1'b1;
            pst_d = SMS_IDLE;
          end else if (pst_q == SMS_NUM && (up == 8'h47 || up == 8'h4B || up == 8'h48)) begin
            unit_d = up;
            pst_d  = SMS_UNIT;
          end else begin
            pst_d = SMS_IDLE;
          end
        end
        SMS_CMD_M: begin
          num_d  = '0;
          frac_d = 4'h0;
          dot_d  = 1'b0;
          unit_d = 8'h48;
          if (char_i == 8'h30) begin
            men_d = '0;
            pst_d = SMS_IDLE;
          end else if (char_i >= 8'h31 && char_i <= 8'h35) begin
            sel_d = 3'(char_i - 8'h30);
            men_d[3'(char_i - 8'h31)] = 1'b1;
            pst_d = SMS_SEL;
          end else if (up == 8'h4F && sel_q != 3'h0) begin
            men_d[sel_q - 3'h1] = 1'b0;
            pst_d = SMS_IDLE;
          end else if (up == 8'h4F) begin
            men_d = '0;
            pst_d = SMS_IDLE;
          end else if (up == 8'h5A && sel_q != 3'h0 && unit_q == 8'h4D) begin
            mfreq_d[sel_q - 3'h1] = rounded[FREQ_W-1:0];
            men_d[sel_q - 3'h1]   = 1'b1;
            pst_d = SMS_IDLE;
          end else begin
            perr_d = ERR_BAD_MKR;
            pst_d  = SMS_IDLE;
          end
        end
        SMS_UNIT: begin
          if (up == 8'h5A) begin
            mfreq_d[sel_q - 3'h1] = rounded[FREQ_W-1:0];
            men_d[sel_q - 3'h1]   = 1'b1;
          end
          pst_d = SMS_IDLE;
        end
        SMS_CMD_W: begin
          if (char_i == 8'h32) begin
            mode_d = 2'(SMS_AUTO);
          end else if (char_i == 8'h33) begin
            mode_d = 2'(SMS_MANUAL);
          end else if (char_i == 8'h36) begin
            mode_d = 2'(SMS_SINGLE);
            arm_d  = 1'b1;
          end
          pst_d = SMS_IDLE;
        end
        default: pst_d = SMS_IDLE;
      endcase
    end
  end
  // Terminator M after number in SEL/NUM enters CMD_M; "MZ" then lands above
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pst_q  <= SMS_IDLE;
      sel_q  <= 3'h0;
      num_q  <= '0;
      frac_q <= 4'h0;
      dot_q  <= 1'b0;
      unit_q <= 8'h48;
      men_q  <= '0;
      mode_q <= 2'(SMS_AUTO);
      perr_q <= ERR_NONE;
      for (int i = 0; i < NUM_MKR; i++) begin
        mfreq_q[i] <= MKR_RST;
      end
    end else begin
      pst_q   <= pst_d;
      sel_q   <= sel_d;
      num_q   <= (pst_q == SMS_NUM && pst_d == SMS_CMD_M) ? num_q : num_d;
      frac_q  <= frac_d;
      dot_q   <= dot_d;
      unit_q  <= unit_d;
      men_q   <= men_d;
      mode_q  <= mode_d;
      perr_q  <= perr_d;
      mfreq_q <= mfreq_d;
    end
  end
  // ****************************************
  // Sweep point generator
  // ****************************************
  logic [FREQ_W-1:0]  cur_q, cur_d;
  logic [NUM_MKR-1:0] done_q, done_d;
  logic               mpt_q, mpt_d, after_q, after_d;
  logic [2:0]         mk_q, mk_d;
  logic [FREQ_W-1:0]  nxt, pbest, pf;
  logic               run_q, run_d;
  logic [NUM_MKR-1:0] inspan, due;
  logic [FREQ_W-1:0]  lo, hi;
  logic [2:0]         pick;
  logic [7:0]         serr;
  always_comb begin
    lo = (start_freq_i < stop_freq_i) ? start_freq_i : stop_freq_i;
    hi = (start_freq_i < stop_freq_i) ? stop_freq_i : start_freq_i;
    // Next ordinary point; markers at or below it are generated first
    nxt = (hi - cur_q < step_freq_i) ? stop_freq_i : cur_q + step_freq_i;
    pf  = mpt_q ? mfreq_q[mk_q] : cur_q;
    for (int i = 0; i < NUM_MKR; i++) begin
      inspan[i] = men_q[i] && mfreq_q[i] >= lo && mfreq_q[i] <= hi;
      // A marker at the start is only reached after the start point
      due[i]    = inspan[i] && !done_q[i] && mfreq_q[i] <= nxt;
    end
    pick  = 3'h0;
    pbest = '1;
    for (int i = 0; i < NUM_MKR; i++) begin
      if (due[i] && mfreq_q[i] < pbest) begin
        pick  = 3'(i + 1);
        pbest = mfreq_q[i];
      end
    end
    serr = ERR_NONE;
    if (start_freq_i == stop_freq_i) begin
      serr = ERR_EQUAL;
    end else if (lo < FREQ_MIN) begin
      serr = ERR_LOW;
    end else if (hi > FREQ_MAX) begin
      serr = ERR_HIGH;
    end
    cur_d   = cur_q;
    done_d  = done_q;
    mpt_d   = mpt_q;
    after_d = 1'b0;
    mk_d    = mk_q;
    run_d   = run_q && serr != ERR_EQUAL;
    if (arm_d || (mode_q == 2'(SMS_AUTO) && !run_q)) begin
      run_d   = serr != ERR_EQUAL;
      cur_d   = start_freq_i;
      done_d  = '0;
      mpt_d   = 1'b0;
    end else if (point_adv_i && run_q) begin
      if (pick != 3'h0) begin
        mpt_d  = 1'b1;
        mk_d   = pick - 3'h1;
        done_d[pick - 3'h1] = 1'b1;
      end else if (cur_q == stop_freq_i) begin
        run_d = mode_q == 2'(SMS_AUTO);
        cur_d = start_freq_i;
        done_d = '0;
        mpt_d  = 1'b0;
      end else begin
        after_d = mpt_q;
        mpt_d   = 1'b0;
        cur_d   = nxt;
      end
    end
  end
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cur_q   <= MKR_RST;
      done_q  <= '0;
      mpt_q   <= 1'b0;
      after_q <= 1'b0;
      mk_q    <= 3'h0;
      run_q   <= 1'b0;
    end else begin
      cur_q   <= cur_d;
      done_q  <= done_d;
      mpt_q   <= mpt_d;
      after_q <= after_d;
      mk_q    <= mk_d;
      run_q   <= run_d;
    end
  end
  // ****************************************
  // Tone, order list, outputs
  // ****************************************
  logic [TONE_W-1:0] tcnt_q, tcnt_d;
  logic              tone_q, tone_d;
  logic [14:0]       ord_d;
  logic [2:0]        rank;
  always_comb begin
    tcnt_d = (tcnt_q == TONE_W'(TONE_HALF - 1)) ? '0 : tcnt_q + 1'b1;
    tone_d = (tcnt_q == TONE_W'(TONE_HALF - 1)) ? ~tone_q : tone_q;
    ord_d  = '0;
    for (int i = 0; i < NUM_MKR; i++) begin
      rank = 3'h0;
      for (int j = 0; j < NUM_MKR; j++) begin
        if (inspan[j] && (mfreq_q[j] < mfreq_q[i]
            || (mfreq_q[j] == mfreq_q[i] && j < i))) begin
          rank = rank + 3'h1;
        end
      end
      if (inspan[i]) begin
        ord_d[rank*3 +: 3] = 3'(i + 1);
      end
    end
  end
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tcnt_q <= '0;
      tone_q <= 1'b0;
      active_order_o     <= '0;
      error_code_o       <= ERR_NONE;
      readback_valid_o   <= 1'b0;
      readback_mkr_o     <= 3'h0;
      readback_freq_o    <= MKR_RST;
      point_freq_o       <= MKR_RST;
      marker_intensify_o <= 1'b0;
      single_arm_o       <= 1'b0;
    end else begin
      tcnt_q <= tcnt_d;
      tone_q <= tone_d;
      active_order_o     <= ord_d;
      error_code_o       <= pk_sync_q[1] ? ERR_PEAK : (serr != ERR_NONE ? serr : perr_q);
      readback_valid_o   <= rb_d;
      readback_mkr_o     <= sel_q;
      readback_freq_o    <= (sel_q != 3'h0) ? mfreq_q[sel_q - 3'h1] : MKR_RST;
      point_freq_o       <= pf < FREQ_MIN ? FREQ_MIN
                            : (pf > FREQ_MAX ? FREQ_MAX : pf);
      marker_intensify_o <= mpt_q && !after_q && run_q;
      single_arm_o       <= arm_d;
    end
  end
  assign tone_marker_output_o = tone_q && marker_intensify_o;
  assign marker_active_o      = inspan;
  assign sweep_mode_o         = mode_q;
  assign sweep_run_o          = run_q;
  // ****************************************
  // Checks
  // ****************************************
  a_equal_no_run: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    start_freq_i == stop_freq_i |=> !run_q)
    else $error("Sweep runs with equal start and stop");
  a_tone_silent: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !marker_intensify_o |-> !tone_marker_output_o)
    else $error("Tone active outside marker point");
  a_w2_auto: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    pst_q == SMS_CMD_W && char_valid_i && char_i == 8'h32 |=> mode_q == 2'(SMS_AUTO))
    else $error("Auto code not decoded");
  a_m0_all_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    pst_q == SMS_CMD_M && char_valid_i && char_i == 8'h30 |=> men_q == '0)
    else $error("Marker zero did not disable all");
  a_bad_num: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    pst_q == SMS_CMD_M && char_valid_i && char_i >= 8'h36 && char_i <= 8'h39
    |=> men_q == $past(men_q) && perr_q == ERR_BAD_MKR)
    else $error("Bad marker number not rejected");
  a_span_active: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    mpt_q && mk_q == 3'h0 |-> mfreq_q[0] >= lo && mfreq_q[0] <= hi)
    else $error("Out of span marker reported active");
  a_peak_err: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    pk_sync_q[1] |=> error_code_o == ERR_PEAK)
    else $error("Auto peak fault not reported");
  a_sel_enable: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    pst_q == SMS_CMD_M && char_valid_i && char_i == 8'h33 |=> men_q[2])
    else $error("Select did not enable marker");
endmodule : sms_sweep_marker_sequencer
`default_nettype wire

// file: test/sms_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Remote host sending program codes
// ****************************************
module sms_host_model (
  input  wire logic       ref_clk_i,
  output logic            char_valid_o,
  output logic [7:0]      char_o
);
  initial begin
    char_valid_o = 1'b0;
    char_o       = 8'h00;
  end
  // One character per cycle, back to back, changed just after the edge
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge ref_clk_i);
      #10;
      char_valid_o = 1'b1;
      char_o       = s[i];
    end
    @(posedge ref_clk_i);
    #10;
    char_valid_o = 1'b0;
    // Released bus shows no stale character
    char_o       = ~char_o;
  endtask : send_str
endmodule : sms_host_model
`default_nettype wire

// file: test/sms_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
  import sms_pkg::*;
;
  // ****************************************
  // Stimulus and monitors
  // ****************************************
  localparam logic [FREQ_W-1:0] F1G  = 36'h0_3B9A_CA00;
  localparam logic [FREQ_W-1:0] F7G  = 36'h1_A13B_8600;
  localparam logic [FREQ_W-1:0] F8G  = 36'h1_DCD6_5000;
  localparam logic [FREQ_W-1:0] F9G  = 36'h2_1871_1A00;
  localparam logic [FREQ_W-1:0] F10G = 36'h2_540B_E400;
  localparam logic [FREQ_W-1:0] F13G = 36'h3_06DC_4200;
  localparam logic [FREQ_W-1:0] F12G = 36'h2_DF85_7500;
  logic                ref_clk_i = 1'b0;
  logic                sys_rst_i, char_valid, point_adv_i, peak_fail_i;
  logic [7:0]          char_byte;
  logic [FREQ_W-1:0]   start_f, stop_f, point_f, rb_f, rb_freq;
  logic [1:0]          mode;
  logic                arm, run, inten, tone, rb_v, rb_seen, arm_seen, tone_prev;
  logic [NUM_MKR-1:0]  act;
  logic [14:0]         order;
  logic [7:0]          err;
  logic [2:0]          rb_m, rb_mkr;
  logic [FREQ_W-1:0]   exp_f [7] = '{F8G, F8G, F9G, F9G, F9G, F9G, F10G};
  logic                exp_m [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  int                  miscompares, samples_checked, cycles, edges;
  always #50 ref_clk_i = ~ref_clk_i;
  sms_host_model host (.ref_clk_i(ref_clk_i), .char_valid_o(char_valid), .char_o(char_byte));
  sms_sweep_marker_sequencer uut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .char_valid_i(char_valid),
    .char_i(char_byte), .start_freq_i(start_f), .stop_freq_i(stop_f),
    .step_freq_i(F1G), .point_adv_i(point_adv_i), .peak_fail_i(peak_fail_i),
    .sweep_mode_o(mode), .single_arm_o(arm), .point_freq_o(point_f), .sweep_run_o(run),
    .marker_intensify_o(inten), .tone_marker_output_o(tone), .marker_active_o(act),
    .active_order_o(order), .error_code_o(err), .readback_valid_o(rb_v),
    .readback_mkr_o(rb_m), .readback_freq_o(rb_f));
  // Pulses are caught mid-cycle, away from the launching edge
  always @(negedge ref_clk_i) begin
    if (rb_v === 1'b1) begin
      rb_seen = 1'b1;
      rb_freq = rb_f;
      rb_mkr  = rb_m;
    end
    if (arm === 1'b1) arm_seen = 1'b1;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #10;
  endtask : settle
  task automatic cmd(input string s);
    rb_seen  = 1'b0;
    arm_seen = 1'b0;
    host.send_str(s);
    settle(4);
  endtask : cmd
  task automatic advance();
    @(posedge ref_clk_i);
    #10;
    point_adv_i = 1'b1;
    settle(1);
    point_adv_i = 1'b0;
    settle(4);
  endtask : advance
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    sys_rst_i = 1'b1; point_adv_i = 1'b0; peak_fail_i = 1'b0;
    start_f = F8G; stop_f = F10G; rb_seen = 1'b0; arm_seen = 1'b0;
    settle(12);
    sys_rst_i = 1'b0;
    check(mode, 2'h0); check(err, ERR_NONE); check(act, 5'h00);
    cmd("W3"); check(mode, 2'h1);
    cmd("w6"); check(mode, 2'h2); check(arm_seen, 1'b1);
    cmd("W2"); check(mode, 2'h0);
    cmd("M312.34GZ"); check(act, 5'h00);
    stop_f = F13G;
    settle(3); check(act, 5'h04);
    cmd("M3?"); check(rb_seen, 1'b1); check(rb_mkr, 3'h3); check(rb_freq, F12G);
    cmd("m510000mz"); check(act, 5'h14); check(order[5:0], 6'h1D);
    cmd("M5MO"); check(act, 5'h04);
    cmd("M5"); check(act, 5'h14);
    cmd("M0"); check(act, 5'h00);
    cmd("M3"); check(act, 5'h04);
    cmd("Mo"); check(act, 5'h00);
    cmd("M17000000001HZ");
    cmd("M1?"); check(rb_freq, F7G); check(act, 5'h00);
    cmd("M3"); cmd("M7"); check(err, ERR_BAD_MKR); check(act, 5'h04);
    stop_f = F10G;
    cmd("M0");
    cmd("M18GZ"); cmd("M29000MZ"); cmd("M49000000000HZ"); cmd("M59000000KZ");
    check(act, 5'h1B); check(order[11:0], 12'hB11);
    cmd("W3");
    for (int k = 0; k < 7; k++) begin
      if (k > 0) advance();
      check(point_f, exp_f[k]);
      check(inten, exp_m[k]);
      if (exp_m[k] == 1'b0) check(tone, 1'b0);
      if (k == 1) begin
        edges = 0;
        repeat (2 * TONE_HALF + 4) begin
          tone_prev = tone;
          settle(1);
          if (tone !== tone_prev) edges++;
        end
        check(edges >= 2 && edges <= 3, 1'b1);
      end
    end
    start_f = F8G; stop_f = F8G;
    settle(4); check(err, ERR_EQUAL);
    start_f = F1G; stop_f = F10G;
    settle(4); check(err, ERR_LOW);
    start_f = F8G; stop_f = 36'h4_FFFF_FFFF;
    settle(4); check(err, ERR_HIGH);
    peak_fail_i = 1'b1;
    settle(6); check(err, ERR_PEAK);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
